// ---- core/uc_uart_channel.sv ----
`include "uc_consts.svh"
module uc_uart_channel (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Baud time base
  input  wire logic        oscillator_input,
  // Serial line
  input  wire logic        rx,
  output logic             tx,
  // Modem control
  input  wire logic        cts_n,
  input  wire logic        dsr_n,
  input  wire logic        ri_n,
  input  wire logic        cd_n,
  output logic             dtr_n,
  output logic             rts_n,
  output logic             op_n,
  output logic             irq
);
  import uc_pkg::*;

  uc_state_type s;
  uc_state_type n;

  logic        setup;
  logic        acc;
  logic        rd_acc;
  logic        wr_acc;
  logic        map_ok;
  logic [31:0] rd;
  logic        tick;
  logic        osc_edge;
  logic        loop;
  logic        fifo_en;
  logic        dma;
  logic [4:0]  cap;
  logic [4:0]  trig;
  logic [4:0]  trig_eff;
  logic        rxi;
  logic [9:0]  head;
  logic        dr;
  logic        thr_space;
  logic        thr_empty;
  logic        temt;
  logic [7:0]  line_status_register;
  logic [3:0]  mcur;
  logic [3:0]  id;
  logic        tpush;
  logic        tpop;
  logic        rpush;
  logic        rpop;
  logic        ier_rise;
  logic [15:0] div;

  assign setup  = psel & ~penable;
  assign acc    = psel & penable;
  assign rd_acc = acc & ~pwrite;
  assign wr_acc = acc & pwrite & pstrb[0];
  assign loop   = s.modem_control_register[`UC_MCR_LOOP];
  assign fifo_en = s.fifo_control_register[`UC_FCR_EN];
  assign dma     = s.fifo_control_register[`UC_FCR_DMA];
  assign cap     = fifo_en ? `UC_FIFO_DEPTH : `UC_NOFIFO_CAP;
  assign head    = s.rxm[s.rrp];
  assign dr      = (s.rcnt != 5'h00);
  assign thr_space = (s.tcnt < cap);
  assign thr_empty = (s.tcnt == 5'h00);
  assign temt      = thr_empty & (s.tst == UC_TX_IDLE);
  assign div       = {s.baud_divisor_high_byte, s.dll};

  always_comb begin
    case (s.fifo_control_register[7:6])
      2'b00:   trig = `UC_TRIG_0;
      2'b01:   trig = `UC_TRIG_1;
      2'b10:   trig = `UC_TRIG_2;
      default: trig = `UC_TRIG_3;
    endcase
  end

  // Mode 0 raises data interrupt per character, mode 1 per block
  assign trig_eff = (fifo_en & dma) ? trig : `UC_TRIG_0;

  // Loop-back: receiver hears own transmitter, pins cut off
  assign rxi = loop ? s.txo : s.filt[4];

  // Modem levels {cd, ri, dsr, cts}, active high
  assign mcur = loop ? {s.modem_control_register[2], s.modem_control_register[`UC_MCR_OUT], s.modem_control_register[1], s.modem_control_register[0]}
                     : {s.filt[0], s.filt[1], s.filt[2], s.filt[3]};

  assign line_status_register = {fifo_en & dr & (head[9] | head[8]), temt, thr_space,
                dr & head[9], dr & head[8], 1'b0, s.oe, dr};

  // Single highest-priority source reported
  always_comb begin
    if (s.interrupt_enable_register[2] & (s.oe | (dr & (head[9] | head[8])))) begin
      id = `UC_ID_LINE;
    end else if (s.interrupt_enable_register[0] & dr & s.toutf) begin
      id = `UC_ID_TOUT;
    end else if (s.interrupt_enable_register[0] & (s.rcnt >= trig_eff)) begin
      id = `UC_ID_RDATA;
    end else if (s.interrupt_enable_register[1] & s.thri) begin
      id = `UC_ID_THR;
    end else if (s.interrupt_enable_register[3] & (|s.dmsr)) begin
      id = `UC_ID_MODEM;
    end else begin
      id = `UC_ID_NONE;
    end
  end

  always_comb begin
    map_ok = 1'b1;
    rd     = 32'h0000_0000;
    case (paddr)
      `UC_OFF_DATA: rd = {24'h00_0000, head[7:0]};
      `UC_OFF_IER:  rd = {28'h000_0000, s.interrupt_enable_register};
      `UC_OFF_ISR:  rd = {24'h00_0000, fifo_en, fifo_en, 2'b00, id};
      `UC_OFF_LCR:  rd = {24'h00_0000, s.lcr};
      `UC_OFF_MCR:  rd = {27'h000_0000, s.modem_control_register};
      `UC_OFF_LSR:  rd = {24'h00_0000, line_status_register};
      `UC_OFF_MSR:  rd = {24'h00_0000, loop ? 4'h0 : mcur, s.dmsr};
      `UC_OFF_SPR:  rd = {24'h00_0000, s.spr};
      `UC_OFF_DLL:  rd = {24'h00_0000, s.dll};
      `UC_OFF_DLM:  rd = {24'h00_0000, s.baud_divisor_high_byte};
      default:      map_ok = 1'b0;
    endcase
  end

  // Oscillator is a pin: accept its rising edge once stages 2 and 3 agree
  assign osc_edge = (s.s2[5] == s.s3[5]) & s.filt[5] & ~s.s2[5];

  always_comb begin
    n        = s;
    tick     = 1'b0;
    tpush    = 1'b0;
    tpop     = 1'b0;
    rpush    = 1'b0;
    rpop     = 1'b0;
    ier_rise = 1'b0;

    n.s1 = ~{oscillator_input, rx, cts_n, dsr_n, ri_n, cd_n};
    n.s2 = s.s1;
    n.s3 = s.s2;
    for (int i = 0; i < 6; i++) begin
      if (s.s2[i] == s.s3[i]) begin
        n.filt[i] = s.s2[i];
      end
    end

    // 16x tick; zero divisor stops the generator
    if (osc_edge && div != 16'h0000) begin
      if (s.bdiv >= div - 16'h0001) begin
        n.bdiv = 16'h0000;
        tick   = 1'b1;
      end else begin
        n.bdiv = s.bdiv + 16'h0001;
      end
    end

    // Transmitter, fixed 8 data bits and one stop bit
    if (tick) begin
      case (s.tst)
        UC_TX_IDLE: begin
          if (!thr_empty) begin
            n.tsh  = {1'b1, s.txm[s.trp]};
            n.trp  = s.trp + 4'h1;
            tpop   = 1'b1;
            n.txo  = 1'b1;
            n.tsub = 4'h0;
            n.tbit = 4'h0;
            n.tst  = UC_TX_SHIFT;
          end
        end
        UC_TX_SHIFT: begin
          n.tsub = s.tsub + 4'h1;
          if (s.tsub == `UC_LAST_SAMP) begin
            n.tbit = s.tbit + 4'h1;
            if (s.tbit == `UC_STOP_BIT) begin
              n.txo = 1'b0;
              n.tst = UC_TX_IDLE;
            end else begin
              n.txo = ~s.tsh[0];
              n.tsh = {1'b1, s.tsh[8:1]};
            end
          end
        end
        default: n.tst = UC_TX_IDLE;
      endcase
    end

    // Receiver, samples each bit at its middle
    if (tick) begin
      case (s.rst)
        UC_RX_IDLE: begin
          if (rxi) begin
            n.rst  = UC_RX_BUSY;
            n.rsub = 4'h0;
            n.rbit = 4'h0;
          end
        end
        UC_RX_BUSY: begin
          n.rsub = s.rsub + 4'h1;
          if (s.rsub == `UC_MID_SAMPLE) begin
            n.rbit = s.rbit + 4'h1;
            if (s.rbit == 4'h0 && !rxi) begin
              n.rst = UC_RX_IDLE;
            end else if (s.rbit == `UC_STOP_BIT) begin
              n.rst  = UC_RX_IDLE;
              n.tout = 10'h000;
              rpush  = 1'b1;
            end else if (s.rbit != 4'h0) begin
              n.rsh = {~rxi, s.rsh[7:1]};
            end
          end
        end
        default: n.rst = UC_RX_IDLE;
      endcase
    end

    // Time-out runs only while data waits
    if (!dr) begin
      n.tout  = 10'h000;
      n.toutf = 1'b0;
    end else if (tick && !rpush) begin
      if (s.tout == 10'(`UC_TOUT_TICKS - 1)) begin
        n.toutf = 1'b1;
      end else begin
        n.tout = s.tout + 10'h001;
      end
    end

    if (setup && !pwrite) begin
      n.rdata = rd;
    end

    // Read side effects clear only what the captured answer showed
    if (rd_acc) begin
      case (paddr)
        `UC_OFF_DATA: begin
          if (dr) begin
            rpop  = 1'b1;
            n.rrp = s.rrp + 4'h1;
          end
          n.tout  = 10'h000;
          n.toutf = 1'b0;
        end
        `UC_OFF_ISR: begin
          if (s.rdata[3:0] == `UC_ID_THR) begin
            n.thri = 1'b0;
          end
        end
        `UC_OFF_LSR: n.oe = s.oe & ~s.rdata[1];
        `UC_OFF_MSR: n.dmsr = s.dmsr & ~s.rdata[3:0];
        default: ;
      endcase
    end

    if (wr_acc) begin
      case (paddr)
        `UC_OFF_DATA: begin
          n.thri = 1'b0;
          if (thr_space) begin
            tpush          = 1'b1;
            n.txm[s.twp]   = pwdata[7:0];
            n.twp          = s.twp + 4'h1;
          end
        end
        `UC_OFF_IER: begin
          n.interrupt_enable_register    = pwdata[3:0];
          ier_rise = pwdata[1] & ~s.interrupt_enable_register[1];
        end
        `UC_OFF_ISR: n.fifo_control_register = {pwdata[7:6], 2'b00, pwdata[3], 2'b00, pwdata[0]};
        `UC_OFF_LCR: n.lcr = pwdata[7:0];
        `UC_OFF_MCR: n.modem_control_register = pwdata[4:0];
        `UC_OFF_SPR: n.spr = pwdata[7:0];
        `UC_OFF_DLL: n.dll = pwdata[7:0];
        `UC_OFF_DLM: n.baud_divisor_high_byte = pwdata[7:0];
        default: ;
      endcase
    end

    // Receive push; overrun drops the new character
    if (rpush) begin
      if (s.rcnt >= cap && !rpop) begin
        n.oe = 1'b1;
        rpush = 1'b0;
      end else begin
        n.rxm[s.rwp] = {rxi & (s.rsh == 8'h00), rxi, s.rsh};
        n.rwp        = s.rwp + 4'h1;
      end
    end
    n.tcnt = s.tcnt + {4'h0, tpush} - {4'h0, tpop};
    n.rcnt = s.rcnt + {4'h0, rpush} - {4'h0, rpop};

    // FIFO resets; toggling enable flushes both sides
    if (wr_acc && paddr == `UC_OFF_ISR) begin
      if (pwdata[`UC_FCR_RXRST] || pwdata[`UC_FCR_EN] != fifo_en) begin
        n.rcnt = 5'h00;
        n.rwp  = 4'h0;
        n.rrp  = 4'h0;
      end
      if (pwdata[`UC_FCR_TXRST] || pwdata[`UC_FCR_EN] != fifo_en) begin
        n.tcnt = 5'h00;
        n.twp  = 4'h0;
        n.trp  = 4'h0;
      end
    end

    // Holding-empty event: on becoming empty, or on enabling while empty
    n.temp_prev = thr_empty;
    if (thr_empty && (!s.temp_prev || ier_rise)) begin
      n.thri = 1'b1;
    end

    // Modem deltas; set wins over a same-cycle clear
    n.mprev = mcur;
    n.dmsr  = n.dmsr | {mcur[3] ^ s.mprev[3], s.mprev[2] & ~mcur[2],
                        mcur[1] ^ s.mprev[1], mcur[0] ^ s.mprev[0]};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign prdata  = s.rdata;
  assign pready  = 1'b1;
  assign pslverr = acc & ~map_ok;

  assign tx    = loop ? 1'b1 : ~s.txo;
  assign dtr_n = ~(s.modem_control_register[0] & ~loop);
  assign rts_n = ~(s.modem_control_register[1] & ~loop);
  assign op_n  = ~(s.modem_control_register[2] & ~loop);

  // Output gated by the OUT enable; mode 1 adds FIFO level requests
  assign irq = s.modem_control_register[`UC_MCR_OUT] & ((id != `UC_ID_NONE)
             | (fifo_en & dma & ((s.tcnt < `UC_FIFO_DEPTH) | (s.rcnt > trig))));
endmodule

// ---- core/uc_consts.svh ----
`ifndef UC_CONSTS_SVH
`define UC_CONSTS_SVH
// How it works
// - Four interrupt sources, each enabled separately
// - Enabled transmitter interrupt flags empty holding register
// - Status shows only highest pending interrupt
// - Modem interrupts lowest, hidden behind higher ones
// - Data and time-out share level, enable bit 0
// - Data interrupt once count reaches trigger in DMA mode 1
// - No time-out while receive FIFO empty
// - Time-out restarts at stop middle, data read
// - Time-out fires after four character times
// - Channel owns its own baud generator
// - Generator accepts external input clock well below the pclk rate
// - Divisor 1..65535 makes 16x sample clock
// - Divisor split into high and low bytes
// - Status bits 5,6: space and transmitter empty
// - FIFO control bit 3 selects DMA mode
// - DMA mode 0 interrupts per transfer
// - DMA mode 1 interrupts on FIFO levels
// - Loop-back joins transmit to receive internally
// - Loop-back feeds modem inputs from control bits
// - Loop-back keeps interrupts; deltas in low bits

// Register byte offsets
`define UC_OFF_DATA  12'h000
`define UC_OFF_IER   12'h004
`define UC_OFF_ISR   12'h008
`define UC_OFF_LCR   12'h00c
`define UC_OFF_MCR   12'h010
`define UC_OFF_LSR   12'h014
`define UC_OFF_MSR   12'h018
`define UC_OFF_SPR   12'h01c
`define UC_OFF_DLL   12'h020
`define UC_OFF_DLM   12'h024

// Interrupt identification codes
`define UC_ID_NONE   4'h1
`define UC_ID_LINE   4'h6
`define UC_ID_RDATA  4'h4
`define UC_ID_TOUT   4'hc
`define UC_ID_THR    4'h2
`define UC_ID_MODEM  4'h0

// Field positions
`define UC_FCR_EN    0
`define UC_FCR_RXRST 1
`define UC_FCR_TXRST 2
`define UC_FCR_DMA   3
`define UC_MCR_OUT   3
`define UC_MCR_LOOP  4

// FIFO and timing
`define UC_FIFO_DEPTH 5'h10
`define UC_NOFIFO_CAP 5'h01
`define UC_TRIG_0     5'h01
`define UC_TRIG_1     5'h04
`define UC_TRIG_2     5'h08
`define UC_TRIG_3     5'h0e
`define UC_SAMPLES    16
`define UC_MID_SAMPLE 4'h7
`define UC_LAST_SAMP  4'hf
`define UC_STOP_BIT   4'h9
`define UC_CHAR_BITS  10
`define UC_TOUT_CHARS 4
`define UC_TOUT_TICKS (`UC_TOUT_CHARS * `UC_CHAR_BITS * `UC_SAMPLES)
`endif

// ---- core/uc_pkg.sv ----
package uc_pkg;
  typedef enum logic [0:0] {UC_TX_IDLE = 1'b0, UC_TX_SHIFT = 1'b1} uc_tx_type;
  typedef enum logic [0:0] {UC_RX_IDLE = 1'b0, UC_RX_BUSY = 1'b1} uc_rx_type;

  // Whole channel state; pin samples are held inverted so reset to zero is idle
  typedef struct packed {
    logic [5:0]        s1;
    logic [5:0]        s2;
    logic [5:0]        s3;
    logic [5:0]        filt;
    logic [3:0]        interrupt_enable_register;
    logic [7:0]        fifo_control_register;
    logic [7:0]        lcr;
    logic [4:0]        modem_control_register;
    logic [7:0]        spr;
    logic [7:0]        dll;
    logic [7:0]        baud_divisor_high_byte;
    logic [15:0]       bdiv;
    logic [15:0][7:0]  txm;
    logic [15:0][9:0]  rxm;
    logic [3:0]        twp;
    logic [3:0]        trp;
    logic [3:0]        rwp;
    logic [3:0]        rrp;
    logic [4:0]        tcnt;
    logic [4:0]        rcnt;
    uc_tx_type         tst;
    logic [3:0]        tsub;
    logic [3:0]        tbit;
    logic [8:0]        tsh;
    logic              txo;
    uc_rx_type         rst;
    logic [3:0]        rsub;
    logic [3:0]        rbit;
    logic [7:0]        rsh;
    logic [9:0]        tout;
    logic              toutf;
    logic              oe;
    logic              thri;
    logic              temp_prev;
    logic [3:0]        dmsr;
    logic [3:0]        mprev;
    logic [31:0]       rdata;
  } uc_state_type;
endpackage

// ---- testbench/uc_uart_asserts.sv ----
`include "uc_consts.svh"
module uc_uart_asserts (
  // APB side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  // Pins
  input wire logic        tx,
  input wire logic        dtr_n,
  input wire logic        rts_n,
  input wire logic        op_n,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] mcr_h;
  logic [3:0] ier_h;
  logic [7:0] dll_h;
  logic       dma_h;
  logic       acc;
  logic       wr;
  logic       rd;
  assign acc = psel && penable;
  assign wr  = acc && pwrite && pstrb[0];
  assign rd  = acc && !pwrite;
  // Shadow copies of control registers, fed from completed writes only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mcr_h <= 5'h00;
      ier_h <= 4'h0;
      dll_h <= 8'h00;
      dma_h <= 1'b0;
    end else if (wr) begin
      if (paddr == `UC_OFF_MCR) mcr_h <= pwdata[4:0];
      if (paddr == `UC_OFF_IER) ier_h <= pwdata[3:0];
      if (paddr == `UC_OFF_DLL) dll_h <= pwdata[7:0];
      if (paddr == `UC_OFF_ISR) dma_h <= pwdata[3] && pwdata[0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Outputs may lag a control write by one cycle, so settled states only
  a_loop_tx: assert property (mcr_h[4] && $past(mcr_h[4]) |-> tx)
    else $error("tx active in loop-back");
  a_loop_modem: assert property (mcr_h[4] && $past(mcr_h[4]) |-> dtr_n && rts_n && op_n)
    else $error("modem outputs driven in loop-back");
  a_modem_drive: assert property (!mcr_h[4] && $stable(mcr_h)
    |-> {op_n, rts_n, dtr_n} == ~mcr_h[2:0])
    else $error("modem outputs differ from control bits");
  a_irq_gate: assert property (!mcr_h[3] && !$past(mcr_h[3]) |-> !irq)
    else $error("irq with output enable clear");
  a_irq_off: assert property (ier_h == 4'h0 && $past(ier_h) == 4'h0 && !dma_h
    && !$past(dma_h) |-> !irq)
    else $error("irq with all sources disabled");
  a_isr_one: assert property (rd && paddr == `UC_OFF_ISR |-> prdata[3:0] inside
    {`UC_ID_NONE, `UC_ID_LINE, `UC_ID_RDATA, `UC_ID_TOUT, `UC_ID_THR, `UC_ID_MODEM})
    else $error("status shows no single interrupt code");
  a_lsr_space: assert property (rd && paddr == `UC_OFF_LSR |-> prdata[5] || !prdata[6])
    else $error("transmitter empty without free space");
  a_div_keep: assert property (rd && paddr == `UC_OFF_DLL |-> prdata == {24'h0, dll_h})
    else $error("divisor low byte lost");
  c_loop_data: cover property (mcr_h[4] && wr && paddr == `UC_OFF_DATA);
  c_irq_rise: cover property ($rose(irq));
  c_tout: cover property (rd && paddr == `UC_OFF_ISR && prdata[3:0] == `UC_ID_TOUT);
endmodule

// ---- testbench/uc_serial_peer.sv ----
module uc_serial_peer #(
  parameter int BIT_NS = 3200
) (
  // Serial line
  input  wire logic tx,
  output logic      rx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got;
  logic [7:0] q[$];
  logic [9:0] fr;
  initial rx = 1'b1;
  // Idle bits after the frame let a caller act as a slow sender
  task automatic send(input logic [7:0] b, input int idle);
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx = fr[i];
      #(BIT_NS);
    end
    #(idle * BIT_NS);
  endtask
  // Samples at bit centres, least significant bit first
  always begin
    @(negedge tx);
    #(BIT_NS * 3 / 2);
    for (int i = 0; i < 8; i++) begin
      got[i] = tx;
      #(BIT_NS);
    end
    q.push_back(got);
  end
endmodule

// ---- testbench/tb_uart_irq_baud_dma_loopback.sv ----
`include "uc_consts.svh"
module tb_uart_irq_baud_dma_loopback;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, osc, tx, irq, erv;
  logic        dtr_n, rts_n, op_n, pready, pslverr, rx;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  int          n_mismatch, comparisons;
  // Modem input pins idle; their paths are reached through loop-back
  uc_uart_channel u_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .oscillator_input(osc), .rx(rx), .tx(tx), .cts_n(1'b1),
    .dsr_n(1'b1), .ri_n(1'b1), .cd_n(1'b1), .dtr_n(dtr_n), .rts_n(rts_n), .op_n(op_n),
    .irq(irq)
  );
  uc_serial_peer u_peer (.tx(tx), .rx(rx));
  task automatic test_done();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 8'h00);
    chk(nm, e, rdv);
  endtask
  task automatic wirq(input int n);
    for (int i = 0; i < n && irq !== 1'b1; i++) @(posedge pclk);
    chk("irq", 1, irq);
  endtask
  task automatic t_basic();
    rdc(`UC_OFF_LSR, 32'h60, "lsr");
    rdc(`UC_OFF_ISR, 32'h01, "isr");
    bus(1'b0, 12'h040, 8'h00);
    chk("bad addr err", 1, erv);
    bus(1'b1, `UC_OFF_MCR, 8'h08);
    bus(1'b1, `UC_OFF_IER, 8'h02);
    chk("irq", 1, irq);
    rdc(`UC_OFF_ISR, 32'h02, "isr thr");
    rdc(`UC_OFF_ISR, 32'h01, "isr done");
    chk("irq", 0, irq);
    bus(1'b1, `UC_OFF_IER, 8'h00);
    bus(1'b1, `UC_OFF_DLL, 8'h5a);
    bus(1'b1, `UC_OFF_DLM, 8'ha5);
    rdc(`UC_OFF_DLL, 32'h5a, "dll");
    rdc(`UC_OFF_DLM, 32'ha5, "dlm");
    bus(1'b1, `UC_OFF_DLL, 8'h01);
    bus(1'b1, `UC_OFF_DLM, 8'h00);
  endtask
  task automatic t_tx();
    bus(1'b1, `UC_OFF_DATA, 8'ha5);
    // Let the next baud tick move the byte into the shifter
    repeat (8) @(posedge pclk);
    rdc(`UC_OFF_LSR, 32'h20, "lsr busy");
    for (int i = 0; i < 2000 && u_peer.q.size() == 0; i++) @(posedge pclk);
    chk("tx byte", 8'ha5, u_peer.q.pop_front());
    repeat (100) @(posedge pclk);
    rdc(`UC_OFF_LSR, 32'h60, "lsr idle");
  endtask
  task automatic t_rx();
    // Trigger level only counts in block mode; irq pin then also follows tx level
    bus(1'b1, `UC_OFF_ISR, 8'h49);
    bus(1'b1, `UC_OFF_IER, 8'h01);
    for (int i = 0; i < 4; i++) begin
      rdc(`UC_OFF_ISR, 32'hc1, "isr below trigger");
      u_peer.send(8'h10 + i[7:0], 0);
    end
    wirq(100);
    rdc(`UC_OFF_ISR, 32'hc4, "isr rx");
    for (int i = 0; i < 4; i++) rdc(`UC_OFF_DATA, 32'h10 + i, "rx byte");
    rdc(`UC_OFF_LSR, 32'h60, "lsr empty");
    bus(1'b1, `UC_OFF_ISR, 8'h01);
    u_peer.send(8'h5e, 1);
    wirq(100);
    rdc(`UC_OFF_DATA, 32'h5e, "rx byte");
  endtask
  task automatic t_loop();
    logic [7:0] m[3];
    logic [7:0] d[3];
    m = '{8'h1b, 8'h1f, 8'h17};
    d = '{8'h02, 8'h08, 8'h04};
    bus(1'b1, `UC_OFF_IER, 8'h09);
    bus(1'b1, `UC_OFF_MCR, 8'h18);
    bus(1'b1, `UC_OFF_DATA, 8'h3c);
    repeat (800) @(posedge pclk);
    chk("peer frames", 0, u_peer.q.size());
    bus(1'b1, `UC_OFF_MCR, 8'h19);
    repeat (10) @(posedge pclk);
    rdc(`UC_OFF_ISR, 32'hc4, "isr over modem");
    rdc(`UC_OFF_DATA, 32'h3c, "loop byte");
    rdc(`UC_OFF_ISR, 32'hc0, "isr modem");
    rdc(`UC_OFF_MSR, 32'h01, "msr cts");
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, `UC_OFF_MCR, m[i]);
      repeat (10) @(posedge pclk);
      rdc(`UC_OFF_MSR, {24'h0, d[i]}, "msr delta");
    end
    bus(1'b1, `UC_OFF_IER, 8'h00);
    bus(1'b1, `UC_OFF_MCR, 8'h0b);
    repeat (2) @(posedge pclk);
    chk("modem out", 3'b001, {dtr_n, rts_n, op_n});
    bus(1'b0, `UC_OFF_MSR, 8'h00);
  endtask
  task automatic t_tout();
    bus(1'b1, `UC_OFF_ISR, 8'hc1);
    bus(1'b1, `UC_OFF_IER, 8'h01);
    u_peer.send(8'h77, 0);
    u_peer.send(8'h88, 0);
    repeat (2400) @(posedge pclk);
    rdc(`UC_OFF_ISR, 32'hc4, "isr early");
    repeat (200) @(posedge pclk);
    wirq(300);
    rdc(`UC_OFF_ISR, 32'hcc, "isr tout");
    rdc(`UC_OFF_DATA, 32'h77, "rx byte");
    rdc(`UC_OFF_DATA, 32'h88, "rx byte");
    repeat (2700) @(posedge pclk);
    rdc(`UC_OFF_ISR, 32'hc1, "isr empty");
    bus(1'b1, `UC_OFF_IER, 8'h00);
    bus(1'b1, `UC_OFF_ISR, 8'h09);
    chk("irq dma1", 1, irq);
    bus(1'b1, `UC_OFF_ISR, 8'h01);
    chk("irq dma0", 0, irq);
  endtask
  initial forever #25 pclk = ~pclk;
  initial forever #100 osc = ~osc;
  initial begin
    pclk    = 1'b0;
    osc     = 1'b0;
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_basic();
    t_tx();
    t_rx();
    t_loop();
    t_tout();
    test_done();
  end
  // Scenarios need about 12000 cycles
  initial begin
    repeat (40000) @(posedge pclk);
    n_mismatch++;
    test_done();
  end
endmodule
bind uc_uart_channel uc_uart_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .tx(tx),
  .dtr_n(dtr_n), .rts_n(rts_n), .op_n(op_n), .irq(irq)
);
